// ### rtl/sdram_cmd_core.sv
// Command decoder, bank state, burst engine and refresh logic of the memory device
`timescale 1ns/1ps
`include "sdram_cmd_defs.svh"
module sdram_cmd_core
  import sdram_cmd_pkg::*;
#(
  parameter int BANKS    = 8,
  parameter int BA_W     = 3,
  parameter int ADDR_W   = 14,
  parameter int COL_W    = 10,
  parameter int DQ_W     = 8,
  parameter int ROW_KEEP = 2,
  parameter int TRP_W    = 4,
  parameter logic [TRP_W-1:0] TRP_CYC = 4'h4,
  parameter int TRFC_W   = 6,
  parameter logic [TRFC_W-1:0] TRFC_CYC = 6'h0c,
  parameter int REFI_W   = 13,
  parameter logic [REFI_W-1:0] REFI_CYC = REFI_W'(`TREFI_CYC)
) (
  input  wire logic              i_clock,
  input  wire logic              i_rstn,
  input  wire logic              i_cke,
  input  wire logic              i_cs_n,
  input  wire logic              i_ras_n,
  input  wire logic              i_cas_n,
  input  wire logic              i_we_n,
  input  wire logic [BA_W-1:0]   i_ba,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_otf_enable,
  input  wire logic              i_fixed_chop,
  input  wire logic [DQ_W-1:0]   i_wdata,
  input  wire logic              i_dm,
  output logic [DQ_W-1:0]        o_rdata,
  output logic                   o_rvalid,
  output logic [BANKS-1:0]       o_bank_open,
  output logic [BANKS-1:0]       o_bank_precharging,
  output logic                   o_burst_active,
  output logic [ADDR_W-1:0]      o_refresh_row,
  output logic                   o_refresh_busy,
  output logic                   o_self_refresh,
  output logic                   o_cmd_error
);

  localparam int MEM_AW = BA_W + ROW_KEEP + COL_W;

  // Storage window: bank, low row bits and column
  logic [DQ_W-1:0]       mem [0:(1<<MEM_AW)-1];

  logic                  cke_prev_ff;
  burst_state_type       state_ff;
  logic [2:0]            beat_ff;
  logic [2:0]            last_beat_ff;
  logic                  chop_ff;
  logic                  auto_pre_ff;
  logic [BA_W-1:0]       bank_ff;
  logic [COL_W-1:0]      col_ff;
  logic [ROW_KEEP-1:0]   row_ff;
  logic [TRFC_W-1:0]     trfc_cnt_ff;
  logic [REFI_W-1:0]     sr_timer_ff;

  logic [2:0]            cmd_code;
  logic                  cmd_taken;
  logic                  is_act;
  logic                  is_read;
  logic                  is_write;
  logic                  is_pre;
  logic                  is_ref;
  logic                  sr_enter;
  logic                  all_idle;
  logic                  access_ok;
  logic                  start_read;
  logic                  start_write;
  logic                  do_refresh;
  logic                  burst_end;
  logic                  auto_pre_done;
  logic                  nxt_chop;
  logic [2:0]            nxt_low;
  logic [MEM_AW-1:0]     beat_addr;
  logic [BANKS-1:0]      act_vec;
  logic [BANKS-1:0]      pre_vec;
  logic [BANKS-1:0]      open_vec;
  logic [BANKS-1:0]      prech_vec;
  logic [ADDR_W-1:0]     open_row [0:BANKS-1];

  // Previous clock enable, for the two-edge command qualification
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      cke_prev_ff <= 1'b0;
    end else begin
      cke_prev_ff <= i_cke;
    end
  end

  // Command decode; deselect and self refresh take nothing new
  assign cmd_code  = {i_ras_n, i_cas_n, i_we_n};
  assign cmd_taken = cke_prev_ff && i_cke && !i_cs_n && !o_self_refresh;
  assign is_act    = cmd_taken && cmd_code == `CMD_ACTIVATE;
  assign is_read   = cmd_taken && cmd_code == `CMD_READ;
  assign is_write  = cmd_taken && cmd_code == `CMD_WRITE;
  assign is_pre    = cmd_taken && cmd_code == `CMD_PRECHARGE;
  assign is_ref    = cmd_taken && cmd_code == `CMD_REFRESH;
  assign sr_enter  = cke_prev_ff && !i_cke && !i_cs_n && !o_self_refresh
                     && cmd_code == `CMD_REFRESH && all_idle && o_refresh_busy == 1'b0;

  assign all_idle  = open_vec == '0;

  // A running burst blocks new accesses so it is never cut short
  assign access_ok   = state_ff == ST_IDLE && !o_refresh_busy && open_vec[i_ba];
  assign start_read  = is_read && access_ok;
  assign start_write = is_write && access_ok;
  assign do_refresh  = is_ref && all_idle && !o_refresh_busy && state_ff == ST_IDLE;

  // Burst length from A12 in on-the-fly mode, else from the fixed setting
  assign nxt_chop = i_otf_enable ? !i_addr[`ADDR_CHOP] : i_fixed_chop;

  assign burst_end     = state_ff != ST_IDLE && beat_ff == last_beat_ff;
  assign auto_pre_done = burst_end && auto_pre_ff;

  // Column order wraps inside four beats when chopped, eight otherwise
  always_comb begin
    nxt_low = col_ff[`COL_LOW_MSB:0] + beat_ff;
    if (chop_ff) begin
      nxt_low = {col_ff[`COL_LOW_MSB], nxt_low[1:0]};
    end
  end
  assign beat_addr = {bank_ff, row_ff, col_ff[COL_W-1:`COL_LOW_MSB+1], nxt_low};

  // Per-bank activate and precharge strobes and trackers
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      assign act_vec[b] = is_act && i_ba == BA_W'(b);
      // All banks on A10 high, else the addressed bank; auto precharge after its burst
      assign pre_vec[b] = (is_pre && (i_addr[`ADDR_AUTO_PRE] || i_ba == BA_W'(b)))
                          || (auto_pre_done && bank_ff == BA_W'(b));

      sdram_bank_tracker #(
        .ROW_W   (ADDR_W),
        .TRP_W   (TRP_W),
        .TRP_CYC (TRP_CYC)
      ) u_bank (
        .i_clock       (i_clock),
        .i_rstn        (i_rstn),
        .i_activate    (act_vec[b]),
        .i_precharge   (pre_vec[b]),
        .i_row         (i_addr),
        .o_open        (open_vec[b]),
        .o_row         (open_row[b]),
        .o_precharging (prech_vec[b])
      );
    end
  endgenerate

  assign o_bank_open        = open_vec;
  assign o_bank_precharging = prech_vec;

  // Burst state machine; without auto precharge the row is simply left open
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_read) begin
            state_ff <= ST_READ;
          end else if (start_write) begin
            state_ff <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (burst_end) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (burst_end) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Burst parameters latched with the command
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      bank_ff      <= '0;
      col_ff       <= '0;
      row_ff       <= '0;
      chop_ff      <= 1'b0;
      auto_pre_ff  <= 1'b0;
      last_beat_ff <= `BL8_LAST;
    end else if (start_read || start_write) begin
      bank_ff      <= i_ba;
      col_ff       <= i_addr[COL_W-1:0];
      row_ff       <= open_row[i_ba][ROW_KEEP-1:0];
      chop_ff      <= nxt_chop;
      auto_pre_ff  <= i_addr[`ADDR_AUTO_PRE];
      last_beat_ff <= nxt_chop ? `BC4_LAST : `BL8_LAST;
    end
  end

  // Beat counter
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      beat_ff <= '0;
    end else if (state_ff == ST_IDLE || burst_end) begin
      beat_ff <= '0;
    end else begin
      beat_ff <= beat_ff + 3'h1;
    end
  end

  // Write beats; a masked byte keeps its old contents
  always_ff @(posedge i_clock) begin
    if (state_ff == ST_WRITE && !i_dm) begin
      mem[beat_addr] <= i_wdata;
    end
  end

  // Read beats, one per clock, registered straight out
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_rdata  <= '0;
      o_rvalid <= 1'b0;
    end else if (state_ff == ST_READ) begin
      o_rdata  <= mem[beat_addr];
      o_rvalid <= 1'b1;
    end else begin
      o_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_burst_active <= 1'b0;
    end else begin
      o_burst_active <= (state_ff != ST_IDLE && !burst_end) || start_read || start_write;
    end
  end

  // Refresh cycle timer; reads, writes and refreshes are refused meanwhile, activate and precharge are still taken
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      trfc_cnt_ff <= '0;
    end else if (do_refresh) begin
      trfc_cnt_ff <= TRFC_CYC;
    end else if (trfc_cnt_ff != '0) begin
      trfc_cnt_ff <= trfc_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_refresh_busy <= 1'b0;
    end else begin
      o_refresh_busy <= do_refresh || trfc_cnt_ff > {{(TRFC_W-1){1'b0}}, 1'b1};
    end
  end

  // Self refresh state; exit is taken when clock enable comes back high
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_self_refresh <= 1'b0;
    end else if (sr_enter) begin
      o_self_refresh <= 1'b1;
    end else if (o_self_refresh && i_cke) begin
      o_self_refresh <= 1'b0;
    end
  end

  // Internal refresh pacing in self refresh; stops if the clock does
  always_ff @(posedge i_clock) begin
    if (!i_rstn || !o_self_refresh) begin
      sr_timer_ff <= '0;
    end else if (sr_timer_ff == REFI_CYC - 1'b1) begin
      sr_timer_ff <= '0;
    end else begin
      sr_timer_ff <= sr_timer_ff + 1'b1;
    end
  end

  // Row counter; address pins are ignored, one step per refresh
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_refresh_row <= '0;
    end else if (do_refresh || sr_enter) begin
      o_refresh_row <= o_refresh_row + 1'b1;
    end else if (o_self_refresh && sr_timer_ff == REFI_CYC - 1'b1) begin
      o_refresh_row <= o_refresh_row + 1'b1;
    end
  end

  // One-cycle flag for a refused read, write or refresh, or an activate during refresh
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_cmd_error <= 1'b0;
    end else begin
      o_cmd_error <= (is_read && !access_ok) || (is_write && !access_ok)
                     || (is_ref && !do_refresh) || (is_act && o_refresh_busy);
    end
  end

endmodule // sdram_cmd_core

// ### rtl/sdram_cmd_defs.svh
// Command encodings, address fields and timing constants for the command core
// Contract
// - Read without auto precharge keeps row open
// - Read with auto precharge closes row after burst
// - OTF mode: A12 low chop four, high eight
// - Running read burst is never cut short
// - Read is RAS high CAS low WE high
// - Write is read encoding with WE low
// - Write takes bank from BA, precharge from A10
// - OTF mode: A12 picks write burst length
// - Byte stored only when its mask is low
// - Precharge: A10 high all banks, else one
// - Other-bank access allowed during auto precharge
// - Precharge of idle bank is no-op, retimes
// - Refresh row comes from internal counter
// - Self refresh keeps data without external clock (here the refresh pacing runs on i_clock and stops with it)
// - Chip select high accepts no new command
`ifndef SDRAM_CMD_DEFS_SVH
`define SDRAM_CMD_DEFS_SVH

// {RAS#, CAS#, WE#} with CS# low
`define CMD_ACTIVATE   3'h3
`define CMD_READ       3'h5
`define CMD_WRITE      3'h4
`define CMD_PRECHARGE  3'h2
`define CMD_REFRESH    3'h1

// Address bit positions
`define ADDR_AUTO_PRE  10
`define ADDR_CHOP      12
`define COL_LOW_MSB    2

// Last beat index of each burst
`define BL8_LAST       3'h7
`define BC4_LAST       3'h3

// Timing
`define CLK_PERIOD_NS  25
`define TREFI_NS       7800
`define TREFI_CYC      (`TREFI_NS / `CLK_PERIOD_NS)

`endif

// ### rtl/sdram_cmd_pkg.sv
// Types shared by the command core
package sdram_cmd_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } burst_state_type;

endpackage

// ### rtl/sdram_bank_tracker.sv
// Per-bank open row and precharge timer
`timescale 1ns/1ps
module sdram_bank_tracker #(
  parameter int ROW_W = 14,
  parameter int TRP_W = 4,
  parameter logic [TRP_W-1:0] TRP_CYC = 4'h4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rstn,
  input  wire logic             i_activate,
  input  wire logic             i_precharge,
  input  wire logic [ROW_W-1:0] i_row,
  output logic                  o_open,
  output logic [ROW_W-1:0]      o_row,
  output logic                  o_precharging
);

  logic [TRP_W-1:0] trp_cnt_ff;

  // Any precharge restarts the timer, even on an idle bank
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      trp_cnt_ff <= '0;
    end else if (i_precharge) begin
      trp_cnt_ff <= TRP_CYC;
    end else if (trp_cnt_ff != '0) begin
      trp_cnt_ff <= trp_cnt_ff - 1'b1;
    end
  end

  // Row stays open until a precharge closes it
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_open <= 1'b0;
      o_row  <= '0;
    end else if (i_precharge) begin
      o_open <= 1'b0;
    end else if (i_activate && !o_open && trp_cnt_ff == '0) begin
      o_open <= 1'b1;
      o_row  <= i_row;
    end
  end

  // Precharging flag mirrors the timer
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_precharging <= 1'b0;
    end else begin
      o_precharging <= i_precharge || trp_cnt_ff > {{(TRP_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // sdram_bank_tracker

// ### verif/sdram_cmd_core_asserts.sv
// Port-level assertions for the memory command core
`timescale 1ns/1ps
`include "sdram_cmd_defs.svh"
module sdram_cmd_core_asserts #(
  parameter int BANKS  = 8,
  parameter int BA_W   = 3,
  parameter int ADDR_W = 14
) (
  input wire logic              i_clock,
  input wire logic              i_rstn,
  input wire logic              i_cke,
  input wire logic              i_cs_n,
  input wire logic              i_ras_n,
  input wire logic              i_cas_n,
  input wire logic              i_we_n,
  input wire logic [BA_W-1:0]   i_ba,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic              i_otf_enable,
  input wire logic              o_rvalid,
  input wire logic [BANKS-1:0]  o_bank_open,
  input wire logic              o_burst_active,
  input wire logic [ADDR_W-1:0] o_refresh_row,
  input wire logic              o_refresh_busy,
  input wire logic              o_self_refresh,
  input wire logic              o_cmd_error
);
  logic       cke_prev_ff;
  logic       take;
  logic [2:0] code;
  logic       rd_ok;
  logic       bl8;
  // Clock enable must have been high on the previous edge too
  always_ff @(posedge i_clock) begin
    if (!i_rstn) cke_prev_ff <= 1'b0;
    else cke_prev_ff <= i_cke;
  end
  // Accepted read; a running burst or refresh makes the core refuse
  assign take  = cke_prev_ff && i_cke && !i_cs_n && !o_self_refresh;
  assign code  = {i_ras_n, i_cas_n, i_we_n};
  assign rd_ok = take && code == `CMD_READ && o_bank_open[i_ba] && !o_burst_active && !o_refresh_busy;
  assign bl8   = i_otf_enable && i_addr[`ADDR_CHOP];
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence s_beats8;
    o_rvalid [*8] ##1 !o_rvalid;
  endsequence
  sequence s_beats4;
    o_rvalid [*4] ##1 !o_rvalid;
  endsequence
  // First beat is registered one edge after the burst state is entered
  chk_read_latency: assert property (rd_ok |=> !o_rvalid ##1 o_rvalid)
    else $error("read data late or early");
  chk_eight_beats: assert property (rd_ok && bl8 |-> ##2 s_beats8)
    else $error("full burst length wrong");
  chk_four_beats: assert property (rd_ok && i_otf_enable && !i_addr[`ADDR_CHOP] |-> ##2 s_beats4)
    else $error("chopped burst length wrong");
  chk_row_kept: assert property (rd_ok && bl8 && !i_addr[`ADDR_AUTO_PRE] |-> ##9 o_bank_open[$past(i_ba, 9)])
    else $error("row closed after plain read");
  chk_auto_close: assert property (rd_ok && bl8 && i_addr[`ADDR_AUTO_PRE]
    |-> ##10 !o_bank_open[$past(i_ba, 10)])
    else $error("row open after auto precharge");
  chk_burst_refuse: assert property (take && code[2:1] == 2'b10 && o_burst_active |=> o_cmd_error)
    else $error("access during burst not refused");
  chk_pre_all: assert property (take && code == `CMD_PRECHARGE && i_addr[`ADDR_AUTO_PRE]
    |-> ##[1:3] o_bank_open == '0)
    else $error("banks left open");
  chk_refresh_row: assert property (take && code == `CMD_REFRESH && o_bank_open == '0 && !o_burst_active
    && !o_refresh_busy |-> ##2 o_refresh_busy && o_refresh_row == ADDR_W'($past(o_refresh_row, 2) + 1))
    else $error("refresh row not advanced");
  // Error shows one edge after the command, read data two edges after
  chk_deselect: assert property (i_cs_n |=> !$rose(o_cmd_error) ##1 !$rose(o_rvalid))
    else $error("deselected command acted on");
endmodule // sdram_cmd_core_asserts

bind sdram_cmd_core sdram_cmd_core_asserts #(.BANKS(BANKS), .BA_W(BA_W), .ADDR_W(ADDR_W)) u_asserts (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_cke(i_cke), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n),
  .i_we_n(i_we_n), .i_ba(i_ba), .i_addr(i_addr), .i_otf_enable(i_otf_enable), .o_rvalid(o_rvalid),
  .o_bank_open(o_bank_open), .o_burst_active(o_burst_active), .o_refresh_row(o_refresh_row),
  .o_refresh_busy(o_refresh_busy), .o_self_refresh(o_self_refresh), .o_cmd_error(o_cmd_error));

// ### verif/sdram_ctl_model.sv
// Memory controller model driving command, address and write data
`timescale 1ns/1ps
`include "sdram_cmd_defs.svh"
module sdram_ctl_model (
  input  wire logic   i_clock,
  output logic        o_cke,
  output logic        o_cs_n,
  output logic [2:0]  o_code,
  output logic [2:0]  o_ba,
  output logic [13:0] o_addr,
  output logic [7:0]  o_wdata,
  output logic        o_dm
);
  // Bus parked before the first command: deselected, enable high, bytes masked
  initial begin
    o_cke   = 1'b1;
    o_cs_n  = 1'b1;
    o_code  = 3'h7;
    o_ba    = 3'h0;
    o_addr  = 14'h0000;
    o_wdata = 8'h00;
    o_dm    = 1'b1;
  end
  // Deselected lines flip so stale values cannot pass for live ones
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clock);
      o_cs_n  <= 1'b1;
      o_addr  <= ~o_addr;
      o_wdata <= ~o_wdata;
    end
  endtask
  // One command, clock enable high with it
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge i_clock);
    o_cke  <= 1'b1;
    o_cs_n <= 1'b0;
    o_code <= c;
    o_ba   <= b;
    o_addr <= a;
  endtask
  // Write beat and its mask, deselected meanwhile
  task automatic beat(input logic [7:0] d, input logic m);
    @(posedge i_clock);
    o_cs_n  <= 1'b1;
    o_wdata <= d;
    o_dm    <= m;
  endtask
  // Row opened only once the precharge time has run out
  task automatic act(input logic [2:0] b, input logic [13:0] r);
    idle(4);
    cmd(`CMD_ACTIVATE, b, r);
  endtask
  // Close every bank, refresh, then stay quiet through the refresh cycle
  task automatic refresh(input logic [13:0] a);
    cmd(`CMD_PRECHARGE, 3'h0, 14'h0400);
    idle(4);
    // Few refreshes per run keep well inside spacing and posting limits
    cmd(`CMD_REFRESH, 3'h0, a);
    idle(12);
  endtask
  // Enable dropped together with a refresh enters self refresh
  task automatic sleep(input int n);
    @(posedge i_clock);
    o_cke  <= 1'b0;
    o_cs_n <= 1'b0;
    o_code <= `CMD_REFRESH;
    idle(n);
  endtask
  // Exit on a deselect; long wait covers a floating data reference
  task automatic wake();
    @(posedge i_clock);
    o_cke <= 1'b1;
    idle(512);
  endtask
endmodule // sdram_ctl_model

// ### verif/tb_sdram_rw_precharge_refresh_cmds.sv
// Self-checking bench for the memory command core
`timescale 1ns/1ps
`include "sdram_cmd_defs.svh"
`define CMP(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sdram_rw_precharge_refresh_cmds;
  logic        clock = 1'b0;
  logic        rstn  = 1'b0;
  logic        otf;
  logic        fchop;
  logic        cke, cs_n, dm, rvalid, burst, rbusy, sref, cerr;
  logic [2:0]  code, ba;
  logic [13:0] addr, rrow, r0;
  logic [7:0]  wdata, rdata, bopen, bpre, e;
  logic [1:0]  rlo [8];
  logic [7:0]  mem [int];
  logic [7:0]  expq [$];
  int          mismatches = 0;
  int          checks_done = 0;
  int          errs = 0;
  int          cyc = 0;
  always #12.5 clock = ~clock;
  sdram_ctl_model ctl (.i_clock(clock), .o_cke(cke), .o_cs_n(cs_n), .o_code(code), .o_ba(ba), .o_addr(addr),
    .o_wdata(wdata), .o_dm(dm));
  sdram_cmd_core #(.REFI_CYC(13'h0008)) DUT (.i_clock(clock), .i_rstn(rstn), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(code[2]), .i_cas_n(code[1]), .i_we_n(code[0]), .i_ba(ba), .i_addr(addr), .i_otf_enable(otf),
    .i_fixed_chop(fchop), .i_wdata(wdata), .i_dm(dm), .o_rdata(rdata), .o_rvalid(rvalid), .o_bank_open(bopen),
    .o_bank_precharging(bpre), .o_burst_active(burst), .o_refresh_row(rrow), .o_refresh_busy(rbusy),
    .o_self_refresh(sref), .o_cmd_error(cerr));
  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Read beats meet the oldest note; error pulses and cycles are counted
  always @(posedge clock) begin
    cyc++;
    if (cerr === 1'b1) errs++;
    if (rvalid === 1'b1) begin
      `CMP(expq.size() != 0, 1'b1)
      if (expq.size() != 0) begin
        e = expq.pop_front();
        `CMP(rdata, e)
      end
    end
    if (cyc == 3000) begin
      mismatches++;
      end_sim();
    end
  end
  // Storage place of beat k; low column bits count up from the start
  function automatic int at(input logic [2:0] b, input logic [9:0] c, input int k);
    return int'({b, rlo[b], c[9:3], 3'(c[2:0] + k)});
  endfunction
  // Write burst; a masked beat leaves the stored byte alone
  task automatic wr(input logic [2:0] b, input logic [9:0] c, input int n, input logic ap, input logic rm);
    logic [7:0] d;
    logic       m;
    ctl.cmd(`CMD_WRITE, b, {1'b0, n == 8, 1'b0, ap, c});
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      m = rm & 1'($urandom);
      ctl.beat(d, m);
      if (!m) mem[at(b, c, k)] = d;
    end
  endtask
  // Read burst; sel drives the chop bit, n is the length the mode implies
  task automatic rd(input logic [2:0] b, input logic [9:0] c, input int n, input logic sel, input logic ap,
                    input int gap);
    ctl.cmd(`CMD_READ, b, {1'b0, sel, 1'b0, ap, c});
    for (int k = 0; k < n; k++) expq.push_back(mem[at(b, c, k)]);
    ctl.idle(gap);
  endtask
  initial begin
    void'($urandom(91));
    otf   <= 1'b1;
    fchop <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    ctl.idle(2);
    #1;
    `CMP(bopen, 8'h00)
    `CMP(rrow, 14'h0000)
    // Two banks, full writes and a masked chopped write, reads in every length mode
    ctl.act(3'h2, 14'h0005);
    rlo[2] = 2'h1;
    ctl.act(3'h5, 14'h0002);
    rlo[5] = 2'h2;
    wr(3'h2, 10'h000, 8, 1'b0, 1'b0);
    wr(3'h5, 10'h000, 8, 1'b0, 1'b0);
    wr(3'h2, 10'h004, 4, 1'b0, 1'b1);
    rd(3'h2, 10'h000, 8, 1'b1, 1'b0, 8);
    rd(3'h2, 10'h004, 4, 1'b0, 1'b0, 4);
    otf   <= 1'b0;
    fchop <= 1'b1;
    rd(3'h2, 10'h000, 4, 1'b1, 1'b0, 4);
    fchop <= 1'b0;
    rd(3'h2, 10'h000, 8, 1'b0, 1'b0, 8);
    otf <= 1'b1;
    // Auto precharge, access to a closed bank, access during a burst
    rd(3'h5, 10'h000, 8, 1'b1, 1'b1, 10);
    ctl.cmd(`CMD_READ, 3'h5, 14'h1000);
    rd(3'h2, 10'h000, 8, 1'b1, 1'b0, 1);
    ctl.cmd(`CMD_WRITE, 3'h2, 14'h1000);
    ctl.idle(8);
    #1;
    `CMP(errs, 2)
    // Precharge of an idle bank still starts its timer
    ctl.cmd(`CMD_PRECHARGE, 3'h6, 14'h0000);
    ctl.idle(2);
    #1;
    `CMP(bpre[6], 1'b1)
    `CMP(bopen[2], 1'b1)
    // Refresh refused with banks open, then done properly twice
    ctl.act(3'h1, 14'h0000);
    ctl.cmd(`CMD_REFRESH, 3'h0, 14'h0000);
    ctl.idle(2);
    ctl.refresh(14'($urandom));
    ctl.refresh(14'($urandom));
    #1;
    `CMP(bopen, 8'h00)
    `CMP(rrow, 14'h0002)
    // Self refresh keeps counting rows and keeps the data
    r0 = rrow;
    ctl.sleep(24);
    #1;
    `CMP(sref, 1'b1)
    `CMP(rrow - r0 > 14'h0002, 1'b1)
    ctl.wake();
    #1;
    `CMP(sref, 1'b0)
    ctl.act(3'h2, 14'h0005);
    rd(3'h2, 10'h000, 8, 1'b1, 1'b0, 10);
    #1;
    `CMP(expq.size() == 0, 1'b1)
    `CMP(errs, 3)
    end_sim();
  end
endmodule // tb_sdram_rw_precharge_refresh_cmds
